/* File: dmdp_ctrl.sv */
// dac soft mute, de-emphasis enables, output phase and adc filter/mute control
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

// ****************************************************************
// sample fifo
// ****************************************************************
module dmdp_fifo #(
   parameter int WIDTH = 144,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic push;
   logic pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_reg[rd_ptr_reg];
   assign count_next = count_reg + CW'(push) - CW'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // full and empty kept as flops so the ready and valid ports are registered
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_next;
         in_ready <= (count_next != FULL_COUNT);
         out_valid <= (count_next != '0);
      end
   end
endmodule : dmdp_fifo

// ****************************************************************
// control block
// ****************************************************************
module dmdp_ctrl
   import dmdp_pkg::*;
#(
   parameter int SAMPLE_W = 24,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mute_pin,
   input wire logic mclk_ratio_low,
   input wire logic dac_in_valid,
   output logic dac_in_ready,
   input wire logic [6*SAMPLE_W-1:0] dac_in_data,
   output logic dac_out_valid,
   input wire logic dac_out_ready,
   output logic [6*SAMPLE_W-1:0] dac_out_data,
   output logic [2:0] per_dac_deemph_out,
   input wire logic adc_in_valid,
   input wire logic [SAMPLE_W-1:0] adc_in_left,
   input wire logic [SAMPLE_W-1:0] adc_in_right,
   output logic adc_out_valid,
   output logic [SAMPLE_W-1:0] adc_out_left,
   output logic [SAMPLE_W-1:0] adc_out_right,
   output logic adc_highpass_en,
   output logic [1:0] adc_osr_code
);
   localparam int W = SAMPLE_W;
   localparam int CH = 6;
   localparam logic signed [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
   localparam logic signed [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};

   // ****************************************************************
   // registers and apb slave
   // ****************************************************************
   logic [8:0] zero_detect_reg;
   logic [8:0] deemph_reg;
   logic [8:0] polarity_reg;
   logic [8:0] smute_reg;
   logic [8:0] adc_ctrl_reg;
   logic [1:0] mute_pin_sync_reg;
   logic [2:0] zero_mute_reg;
   logic full_mute_reg;

   wire [7:0] reg_idx = paddr[9:2];
   wire hit_zero = (reg_idx == DMDP_IDX_ZERO_DETECT);
   wire hit_deemph = (reg_idx == DMDP_IDX_DEEMPH);
   wire hit_pol = (reg_idx == DMDP_IDX_POLARITY);
   wire hit_smute = (reg_idx == DMDP_IDX_SOFT_MUTE);
   wire hit_adc = (reg_idx == DMDP_IDX_ADC_CTRL);
   wire hit_status = (reg_idx == DMDP_IDX_STATUS);
   wire addr_ok = (paddr[1:0] == 2'h0) &
                  (hit_zero | hit_deemph | hit_pol | hit_smute | hit_adc | hit_status);
   wire access = psel & penable;
   wire commit_wr = access & pready & pwrite & addr_ok;
   wire [8:0] wdat = pwdata[8:0];

   wire mute_pin_s = mute_pin_sync_reg[1];
   wire zdet_en = zero_detect_reg[DMDP_ZERO_DETECT_EN_BIT];
   wire [1:0] zfm_sel = zero_detect_reg[DMDP_ZFM_SEL_LSB +: 2];
   wire mpd_sel = smute_reg[DMDP_MUTE_PIN_DECODE_BIT];

   logic [2:0] soft_eff;
   wire [8:0] status_word = {1'b0, mute_pin_s, full_mute_reg, zero_mute_reg, soft_eff};
   wire [8:0] rd_mux = hit_zero ? zero_detect_reg :
                       hit_deemph ? deemph_reg :
                       hit_pol ? polarity_reg :
                       hit_smute ? smute_reg :
                       hit_adc ? adc_ctrl_reg :
                       hit_status ? status_word : 9'h000;

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~addr_ok;
         if (access & ~pready) begin
            prdata <= (~pwrite & addr_ok) ? {23'h000000, rd_mux} : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         zero_detect_reg <= DMDP_ZERO_DETECT_RST;
         deemph_reg <= DMDP_DEEMPH_RST;
         polarity_reg <= DMDP_POLARITY_RST;
         smute_reg <= DMDP_SOFT_MUTE_RST;
         adc_ctrl_reg <= DMDP_ADC_CTRL_RST;
      end else if (commit_wr) begin
         if (hit_zero) zero_detect_reg <= wdat;
         if (hit_deemph) deemph_reg <= wdat;
         if (hit_pol) polarity_reg <= wdat;
         if (hit_smute) smute_reg <= wdat;
         if (hit_adc) adc_ctrl_reg <= wdat;
      end
   end

   // ****************************************************************
   // mute decode
   // ****************************************************************
   // the pin is asynchronous; only the second stage is read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mute_pin_sync_reg <= 2'h0;
      end else begin
         mute_pin_sync_reg <= {mute_pin_sync_reg[0], mute_pin};
      end
   end

   // selector value 3 picks no dac
   wire [2:0] zfm_onehot = (zfm_sel == 2'h0) ? 3'b001 :
                           (zfm_sel == 2'h1) ? 3'b010 :
                           (zfm_sel == 2'h2) ? 3'b100 : 3'b000;
   wire [2:0] pin_mute = mute_pin_s ? (mpd_sel ? 3'b111 : zfm_onehot) : 3'b000;
   wire [2:0] master_mute = {3{smute_reg[DMDP_GLOBAL_MUTE_BIT]}};
   assign soft_eff = smute_reg[2:0] | master_mute | pin_mute;

   // ****************************************************************
   // sample fifo and step
   // ****************************************************************
   logic fifo_valid;
   logic [CH*W-1:0] fifo_data;
   wire step = fifo_valid & (~dac_out_valid | dac_out_ready);

   dmdp_fifo #(
      .WIDTH(CH * W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(sys_clk),
      .rst(rst),
      .in_valid(dac_in_valid),
      .in_ready(dac_in_ready),
      .in_data(dac_in_data),
      .out_valid(fifo_valid),
      .out_ready(~dac_out_valid | dac_out_ready),
      .out_data(fifo_data)
   );

   // ****************************************************************
   // zero detect and full mute counters
   // ****************************************************************
   logic [10:0] zrun_reg [0:2];
   logic [2:0] zero_mute_now;
   logic [10:0] srun_reg;
   wire all_soft = &soft_eff;
   wire [10:0] srun_next = ~all_soft ? 11'h000 :
                           (srun_reg == DMDP_FULL_MUTE_SAMPLES) ? srun_reg : srun_reg + 11'h001;
   wire full_mute_now = zdet_en & (srun_next == DMDP_FULL_MUTE_SAMPLES);

   genvar gd;
   generate
      for (gd = 0; gd < 3; gd++) begin : g_dac
         wire both_zero = (fifo_data[2*gd*W +: W] == '0) & (fifo_data[(2*gd+1)*W +: W] == '0);
         wire [10:0] zrun_next = ~both_zero ? 11'h000 :
                                 (zrun_reg[gd] == DMDP_ZERO_RUN_SAMPLES) ? zrun_reg[gd] :
                                 zrun_reg[gd] + 11'h001;
         // a non-zero sample on either channel clears the run at once
         assign zero_mute_now[gd] = zdet_en & (zrun_next == DMDP_ZERO_RUN_SAMPLES);
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               zrun_reg[gd] <= 11'h000;
            end else if (step) begin
               zrun_reg[gd] <= zrun_next;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         srun_reg <= 11'h000;
         full_mute_reg <= 1'b0;
         zero_mute_reg <= 3'h0;
      end else if (step) begin
         srun_reg <= srun_next;
         full_mute_reg <= full_mute_now;
         zero_mute_reg <= zero_mute_now;
      end
   end

   // ****************************************************************
   // per channel soft mute, hard mute and phase
   // ****************************************************************
   logic signed [W-1:0] held_reg [0:CH-1];
   logic signed [W-1:0] out_ch [0:CH-1];
   logic signed [W-1:0] in_ch [0:CH-1];

   genvar gc;
   generate
      for (gc = 0; gc < CH; gc++) begin : g_ch
         localparam int D = gc / 2;
         wire signed [W-1:0] sh = held_reg[gc] >>> DMDP_DECAY_SHIFT;
         // below one step the shift stalls on a positive tail, which snaps to mid-scale; a negative tail climbs by one per sample
         wire signed [W-1:0] dec = (sh == '0) ? held_reg[gc] : sh;
         wire signed [W-1:0] held_next = soft_eff[D] ? held_reg[gc] - dec : in_ch[gc];
         wire hard = full_mute_now | zero_mute_now[D];
         wire signed [W-1:0] level = hard ? '0 : held_next;
         assign in_ch[gc] = fifo_data[gc*W +: W];
         // negation saturates so the most negative code cannot wrap
         assign out_ch[gc] = ~polarity_reg[gc] ? level :
                             (level == SMIN) ? SMAX : -level;
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               held_reg[gc] <= '0;
            end else if (step) begin
               held_reg[gc] <= held_next;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // output stage
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dac_out_valid <= 1'b0;
         dac_out_data <= '0;
      end else begin
         if (step) begin
            dac_out_valid <= 1'b1;
            dac_out_data <= {out_ch[5], out_ch[4], out_ch[3], out_ch[2], out_ch[1], out_ch[0]};
         end else if (dac_out_ready) begin
            dac_out_valid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // de-emphasis and adc controls
   // ****************************************************************
   wire adc_l_mute = adc_ctrl_reg[DMDP_ADC_LEFT_MUTE_BIT] | adc_ctrl_reg[DMDP_ADC_BOTH_MUTE_BIT];
   wire adc_r_mute = adc_ctrl_reg[DMDP_ADC_RIGHT_MUTE_BIT] | adc_ctrl_reg[DMDP_ADC_BOTH_MUTE_BIT];
   wire osr_halve = adc_ctrl_reg[DMDP_ADC_OSR_HALVE_BIT];
   // software owns the choice of halving for high sample rates
   wire [1:0] osr_code = mclk_ratio_low ? (osr_halve ? DMDP_OSR_32FS : DMDP_OSR_64FS) :
                         (osr_halve ? DMDP_OSR_64FS : DMDP_OSR_128FS);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         per_dac_deemph_out <= 3'h0;
         adc_highpass_en <= 1'b1;
         adc_osr_code <= DMDP_OSR_128FS;
         adc_out_valid <= 1'b0;
         adc_out_left <= '0;
         adc_out_right <= '0;
      end else begin
         per_dac_deemph_out <= deemph_reg[2:0] | {3{deemph_reg[DMDP_GLOBAL_DEEMPH_BIT]}};
         adc_highpass_en <= ~adc_ctrl_reg[DMDP_ADC_HPF_BYPASS_BIT];
         adc_osr_code <= osr_code;
         adc_out_valid <= adc_in_valid;
         if (adc_in_valid) begin
            adc_out_left <= adc_l_mute ? '0 : adc_in_left;
            adc_out_right <= adc_r_mute ? '0 : adc_in_right;
         end
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   sequence s_take_muted0;
      step && soft_eff[0] && !full_mute_now && !zero_mute_now[0] && held_reg[0] > 0;
   endsequence

   sequence s_take_open0;
      step && !soft_eff[0] && !full_mute_now && !zero_mute_now[0];
   endsequence

   AST_DAC_MUTE_BIT: assert property (@(posedge sys_clk) disable iff (rst)
      smute_reg[1] |-> soft_eff[1]) else $error("per-dac mute bit did not mute dac2");

   AST_MASTER_MUTE: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(smute_reg[DMDP_GLOBAL_MUTE_BIT]) |-> soft_eff == 3'b111)
      else $error("master mute did not reach all dacs");

   AST_PIN_SELECT: assert property (@(posedge sys_clk) disable iff (rst)
      mute_pin_s && !mpd_sel && zfm_sel == 2'h2 && smute_reg[4:0] == 5'h00
      |-> soft_eff == 3'b100) else $error("mute pin muted the wrong dac");

   AST_PIN_ALL: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(mute_pin) && mpd_sel ##2 mpd_sel |-> soft_eff == 3'b111)
      else $error("decoded mute pin did not mute all dacs");

   AST_DECAY: assert property (@(posedge sys_clk) disable iff (rst)
      s_take_muted0 |=> held_reg[0] < $past(held_reg[0]) && held_reg[0] >= 0)
      else $error("soft mute did not decay toward mid-scale");

   AST_FULL_MUTE: assert property (@(posedge sys_clk) disable iff (rst)
      step && full_mute_now |=> dac_out_valid && dac_out_data == '0)
      else $error("full mute left a non-zero output");

   AST_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)
      s_take_open0 |=> held_reg[0] == $past(in_ch[0]))
      else $error("release did not resume from the input sample");

   AST_PHASE: assert property (@(posedge sys_clk) disable iff (rst)
      (s_take_open0 and (polarity_reg[0] && in_ch[0] != SMIN))
      |=> $signed(dac_out_data[W-1:0]) == -$past(in_ch[0]))
      else $error("inverted channel not negated");

   AST_DEEMPH: assert property (@(posedge sys_clk) disable iff (rst)
      deemph_reg[DMDP_GLOBAL_DEEMPH_BIT] ##1 deemph_reg[DMDP_GLOBAL_DEEMPH_BIT]
      |-> per_dac_deemph_out == 3'b111) else $error("global de-emphasis not applied");

   AST_ADC_MUTE: assert property (@(posedge sys_clk) disable iff (rst)
      adc_in_valid && adc_ctrl_reg[DMDP_ADC_BOTH_MUTE_BIT]
      |=> adc_out_left == '0 && adc_out_right == '0)
      else $error("adc all-mute left data through");

   AST_ZERO_LIFT: assert property (@(posedge sys_clk) disable iff (rst)
      step && in_ch[0] != '0 && !soft_eff[0] && !full_mute_now
      |=> dac_out_data[W-1:0] != '0) else $error("zero mute did not lift");

   AST_OSR: assert property (@(posedge sys_clk) disable iff (rst)
      mclk_ratio_low && osr_halve ##1 mclk_ratio_low && osr_halve
      |-> adc_osr_code == DMDP_OSR_32FS) else $error("oversampling not halved");

endmodule : dmdp_ctrl

/* File: dmdp_ctrl_tb.sv */
// testbench for the dac/adc mute, de-emphasis and phase control block
`timescale 1ns/1ps
// *****
// bench
// *****
module dmdp_ctrl_tb;
   import dmdp_pkg::*;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic mute_pin = 0, mclk_ratio_low = 0, dac_out_ready = 0, adc_in_valid = 0;
   logic [9:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic pready, pslverr, dac_in_valid, dac_in_ready, dac_out_valid, e;
   logic [143:0] dac_in_data, dac_out_data, o;
   logic [2:0] per_dac_deemph_out;
   logic adc_out_valid, adc_highpass_en;
   logic [23:0] adc_in_left = 24'h000123, adc_in_right = 24'h000456;
   logic [23:0] adc_out_left, adc_out_right, v = 24'h010000;
   logic [23:0] p[3];
   logic [1:0] adc_osr_code;
   logic [143:0] outq[$];
   logic [8:0] mc[6] = '{9'h001, 9'h002, 9'h004, 9'h012, 9'h000, 9'h080};
   logic [8:0] zs[6] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h002, 9'h000};
   logic pn[6] = '{0, 0, 0, 0, 1, 1};
   logic [2:0] mk[6] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h4, 3'h7};
   logic [8:0] ac[6] = '{9'h000, 9'h001, 9'h002, 9'h004, 9'h008, 9'h01b};
   logic [8:0] dv[3] = '{9'h005, 9'h012, 9'h002};
   logic [2:0] de[3] = '{3'h5, 3'h7, 3'h2};
   int errors = 0, total_checks = 0;
   always #4 sys_clk = ~sys_clk;
   dmdp_src_model i_src (.sys_clk, .rst, .dac_in_ready, .dac_in_valid, .dac_in_data);
   dmdp_ctrl i_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .mute_pin, .mclk_ratio_low, .dac_in_valid, .dac_in_ready,
      .dac_in_data, .dac_out_valid, .dac_out_ready, .dac_out_data, .per_dac_deemph_out,
      .adc_in_valid, .adc_in_left, .adc_in_right, .adc_out_valid, .adc_out_left,
      .adc_out_right, .adc_highpass_en, .adc_osr_code);
   always @(posedge sys_clk) if (dac_out_valid === 1'b1 && dac_out_ready) outq.push_back(dac_out_data);
   task finish_test;
      if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task chk(input logic [143:0] got, input logic [143:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      // no wait count is assumed; only the watchdog ends a hung transfer
      do begin @(posedge sys_clk); end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task wr(input logic [9:0] a, input logic [31:0] d);
      apb(1, a, d);
      chk(e, 0);
   endtask : wr
   task rd(input logic [9:0] a, input logic [31:0] x);
      apb(0, a, 0);
      chk(r, x);
   endtask : rd
   task xfer(input logic [143:0] f);
      int n;
      i_src.q.push_back(f);
      dac_out_ready <= 1;
      n = 0;
      while (outq.size() == 0 && n < 200) begin @(posedge sys_clk); n++; end
      o = (outq.size() > 0) ? outq.pop_front() : 'x;
   endtask : xfer
   function automatic logic [143:0] fr(input logic [23:0] lv, input logic [23:0] rv);
      return {3{rv, lv}};
   endfunction : fr
   // decay step: an arithmetic shift by six stands in for the 64-sample constant
   function automatic logic [23:0] dec(input logic [23:0] x);
      return x - 24'($signed(x) >>> 6);
   endfunction : dec
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 0;
      rd(10'h040, 0); rd(10'h044, 0); rd(10'h04c, 0); rd(10'h074, 0);
      rd(10'h048, 32'h3f);
      apb(0, 10'h3fc, 0); chk({e, r}, 33'h100000000);
      chk(adc_highpass_en, 1); chk(per_dac_deemph_out, 0);
      for (int c = 0; c < 3; c++) begin
         wr(10'h044, dv[c]);
         repeat (2) @(posedge sys_clk);
         chk(per_dac_deemph_out, de[c]);
      end
      wr(10'h048, 0);
      for (int i = 0; i < 12; i++) i_src.q.push_back(fr(24'(i), ~24'(i)));
      repeat (30) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({dac_in_ready, dac_out_valid}, 2'b01);
      @(posedge sys_clk);
      dac_out_ready <= 1;
      repeat (40) @(posedge sys_clk);
      chk(outq.size(), 12);
      for (int i = 0; i < 12; i++) chk(outq.pop_front(), fr(24'(i), ~24'(i)));
      wr(10'h048, 9'h015);
      xfer(fr(24'd100, 24'd100)); chk(o, fr(24'hffff9c, 24'd100));
      wr(10'h048, 0);
      xfer(fr(v, v)); chk(o, fr(v, v));
      p = '{v, v, v};
      for (int c = 0; c < 6; c++) begin
         wr(10'h040, zs[c]); wr(10'h04c, mc[c]); mute_pin <= pn[c];
         repeat (4) @(posedge sys_clk);
         for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 3; i++) p[i] = mk[c][i] ? dec(p[i]) : v;
            xfer(fr(v, v)); chk(o, {p[2], p[2], p[1], p[1], p[0], p[0]});
         end
         wr(10'h04c, 0); mute_pin <= 0;
         repeat (4) @(posedge sys_clk);
         xfer(fr(v, v)); chk(o, fr(v, v));
         p = '{v, v, v};
      end
      wr(10'h040, 9'h080); wr(10'h04c, 9'h010);
      for (int i = 0; i < 1030; i++) xfer('0);
      rd(10'h080, 32'h7f);
      wr(10'h04c, 0);
      xfer(fr(v, v)); chk(o, fr(v, v));
      for (int m = 0; m < 2; m++) for (int c = 0; c < 6; c++) begin
         mclk_ratio_low <= m[0];
         wr(10'h074, ac[c]);
         @(posedge sys_clk) adc_in_valid <= 1;
         @(posedge sys_clk) adc_in_valid <= 0;
         @(negedge sys_clk);
         chk(adc_out_valid, 1);
         chk(adc_out_left, (ac[c][0] | ac[c][2]) ? 24'h0 : adc_in_left);
         chk(adc_out_right, (ac[c][1] | ac[c][2]) ? 24'h0 : adc_in_right);
         chk(adc_highpass_en, !ac[c][4]);
         chk(adc_osr_code, 2'(m) + 2'(ac[c][3]));
      end
      finish_test();
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      errors++;
      finish_test();
   end
endmodule : dmdp_ctrl_tb

/* File: dmdp_pkg.sv */
// constants shared by the dac/adc mute, de-emphasis and phase control block
package dmdp_pkg;

   // ****************************************************************
   // register indices; the byte address is four times the index
   // ****************************************************************
   localparam logic [7:0] DMDP_IDX_ZERO_DETECT = 8'h10;
   localparam logic [7:0] DMDP_IDX_DEEMPH = 8'h11;
   localparam logic [7:0] DMDP_IDX_POLARITY = 8'h12;
   localparam logic [7:0] DMDP_IDX_SOFT_MUTE = 8'h13;
   localparam logic [7:0] DMDP_IDX_ADC_CTRL = 8'h1d;
   localparam logic [7:0] DMDP_IDX_STATUS = 8'h20;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [8:0] DMDP_ZERO_DETECT_RST = 9'h000;
   localparam logic [8:0] DMDP_DEEMPH_RST = 9'h000;
   localparam logic [8:0] DMDP_POLARITY_RST = 9'h03f;
   localparam logic [8:0] DMDP_SOFT_MUTE_RST = 9'h000;
   localparam logic [8:0] DMDP_ADC_CTRL_RST = 9'h000;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int DMDP_ZFM_SEL_LSB = 0;
   localparam int DMDP_ZERO_DETECT_EN_BIT = 7;
   localparam int DMDP_GLOBAL_DEEMPH_BIT = 4;
   localparam int DMDP_GLOBAL_MUTE_BIT = 4;
   localparam int DMDP_MUTE_PIN_DECODE_BIT = 7;
   localparam int DMDP_ADC_LEFT_MUTE_BIT = 0;
   localparam int DMDP_ADC_RIGHT_MUTE_BIT = 1;
   localparam int DMDP_ADC_BOTH_MUTE_BIT = 2;
   localparam int DMDP_ADC_OSR_HALVE_BIT = 3;
   localparam int DMDP_ADC_HPF_BYPASS_BIT = 4;

   // ****************************************************************
   // timing in input samples
   // ****************************************************************
   localparam int DMDP_DECAY_TC_SAMPLES = 64;
   localparam int DMDP_DECAY_SHIFT = $clog2(DMDP_DECAY_TC_SAMPLES);
   localparam logic [10:0] DMDP_FULL_MUTE_SAMPLES = 11'h400;
   localparam logic [10:0] DMDP_ZERO_RUN_SAMPLES = 11'h400;

   // ****************************************************************
   // adc oversampling codes
   // ****************************************************************
   localparam logic [1:0] DMDP_OSR_128FS = 2'h0;
   localparam logic [1:0] DMDP_OSR_64FS = 2'h1;
   localparam logic [1:0] DMDP_OSR_32FS = 2'h2;

endpackage : dmdp_pkg

/* File: dmdp_src_model.sv */
// audio receiver model that feeds dac frames into the control block
`timescale 1ns/1ps
// *****
// frame source
// *****
module dmdp_src_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic dac_in_ready,
   output logic dac_in_valid,
   output logic [143:0] dac_in_data = '0
);
   logic [143:0] q[$];
   always @(posedge sys_clk) begin
      if (rst) begin
         dac_in_valid <= 1'b0;
      end else if (!dac_in_valid || dac_in_ready) begin
         if (q.size() > 0) begin
            dac_in_valid <= 1'b1;
            dac_in_data <= q.pop_front();
         end else begin
            // idle data keeps toggling so a stale frame is never mistaken for a new one
            dac_in_valid <= 1'b0;
            dac_in_data <= ~dac_in_data;
         end
      end
   end
endmodule : dmdp_src_model
